// File: adc_cfg_pkg.sv
package adc_cfg_pkg;
    // Register addresses carried in the top nibble of every word
    localparam logic [3:0]  ADDR_READ_SELECT = 4'h0;
    localparam logic [3:0]  ADDR_CFG_ONE     = 4'h1;
    localparam logic [3:0]  ADDR_CFG_TWO     = 4'h2;
    localparam int          ADDR_MSB         = 15;
    localparam int          ADDR_LSB         = 12;
    // Second configuration register field positions
    localparam int          LANE_COUNT_BIT   = 8;
    localparam int          RESET_CODE_MSB   = 7;
    // Reset command codes
    localparam logic [7:0]  RESET_CODE_SOFT  = 8'h3C;
    localparam logic [7:0]  RESET_CODE_HARD  = 8'hFF;
    // Averaging ratio codes (001..101 active)
    localparam logic [2:0]  RATIO_CODE_MIN   = 3'h1;
    localparam logic [2:0]  RATIO_CODE_MAX   = 3'h5;
    // Power-up values
    localparam logic [11:0] CFG_ONE_RESET    = 12'h000;
    localparam logic        LANE_RESET       = 1'b0;
    localparam logic [3:0]  READ_SEL_RESET   = ADDR_CFG_ONE;
    // Frame geometry in serial clock edges
    localparam int          CMD_BITS         = 16;
    localparam int          CHECK_BITS       = 8;
    localparam int          FRAME_BITS       = CMD_BITS + CHECK_BITS;
    localparam logic [4:0]  CNT_CMD_ONLY     = 5'h10;
    localparam logic [4:0]  CNT_WITH_CHECK   = 5'h18;
    localparam logic [4:0]  CNT_OVERLONG     = 5'h19;
    // Check code: polynomial x^8+x^2+x+1, seed zero
    localparam logic [7:0]  CHECK_POLY       = 8'h07;
    localparam logic [7:0]  CHECK_SEED       = 8'h00;

    // First configuration register layout, bits 11..0
    typedef struct packed {
        logic       chan_sel;
        logic       seq_en;
        logic       avg_rolling;
        logic [2:0] averaging_ratio;
        logic       write_check_en;
        logic       read_check_en;
        logic       alarm_pin_sel;
        logic       resolution_boost;
        logic       reference_source_select;
        logic       power_down_select;
    } cfg_one_t;

    // Mode bits handed to the serial clock domain
    typedef struct packed {
        logic       read_check_en;
        logic       two_lane;
        logic       alarm_mode;
    } link_mode_t;
endpackage

// File: adc_config_control_regs.sv
// Operation
// - Setting write check needs valid check code
// - Bad or missing check discards whole frame
// - Clearing write check needs valid check code
// - Read check appends code on output pins
// - Alarm select honoured only in one-lane mode
// - Alarm select picks data or alarm pin
// - Resolution boost widens result two bits
// - Averaging off forces default resolution
// - Reference select: internal zero, external one
// - Power-down select: normal zero, down one
// - Top nibble of each word is address
// - Lane count: both pins or primary only
// - Code 3C soft reset keeps registers
// - Code FF hard reset restores all defaults
// - Other reset codes do nothing
// - Ratio codes 001..101 active, others off
// - Setup fault cleared only by hard reset
`timescale 1ns/1ps
`default_nettype none
module adc_config_control_regs
    import adc_cfg_pkg::*;
(
    // System clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Serial register link
    input  wire logic       link_sclk,
    input  wire logic       cs_n,
    input  wire logic       serial_input_line,
    output logic            primary_serial_out,
    output logic            secondary_out_alarm_pin,
    // Status from the rest of the converter
    input  wire logic       alarm_level,
    input  wire logic       setup_fault_set,
    // Configuration outputs
    output logic            resolution_boost,
    output logic            averaging_on,
    output logic [2:0]      averaging_ratio,
    output logic            reference_external,
    output logic            power_down,
    output logic            output_lane_count,
    // Reset command pulses and status
    output logic            soft_reset_pulse,
    output logic            hard_reset_pulse,
    output logic            frame_discard_pulse,
    output logic            setup_fault_flag
);

    ////////////////////////////////////////////////////////////////////
    // Shared check code over one command or readback word
    function automatic logic [7:0] check_code(input logic [15:0] data);
        logic [7:0] c;
        logic       fb;
        c  = CHECK_SEED;
        fb = 1'b0;
        for (int i = CMD_BITS - 1; i >= 0; i--) begin
            fb = c[7] ^ data[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CHECK_POLY : 8'h00);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link domain: receive shifter, bit counter, transmit shifter
    logic [23:0]  rx_sh_ff;      // Incoming bits, newest at bit 0
    logic [4:0]   bit_cnt_ff;    // Edges seen this frame, saturating
    logic         in_frame_ff;   // An edge has been seen since select fell
    logic         frm_tog_ff;    // Flips on each frame's first edge
    logic [23:0]  tx_sh_ff;      // Outgoing readback bits
    logic         pri_ff;        // Primary output pin
    logic         sec_ff;        // Shared secondary/alarm pin
    logic         al_s1_ff;      // Alarm synchroniser, first stage
    logic         al_s2_ff;      // Alarm synchroniser, second stage
    wire logic    link_clr;      // Frame marker and readback side cleared between frames
    wire logic    first_edge;    // First edge of a frame
    wire logic    next_out;      // Bit presented on this edge

    // Ref-domain words read by the link; they only change between frames
    logic [15:0]  rb_word_ff;    // Readback word with address nibble
    logic [7:0]   rb_check_ff;   // Check code of the readback word
    link_mode_t   mode_ff;       // Lane, alarm and read-check modes

    // Select high clears only the frame marker and the readback side; the
    // count and shifter must hold until the ref side has read them
    assign link_clr   = rst | cs_n;
    assign first_edge = !in_frame_ff;
    assign next_out   = first_edge ? rb_word_ff[15] : tx_sh_ff[23];

    // Shift in on each rising edge; count restarts on a frame's first edge
    // and holds after the frame, so the ref side reads a still word
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            rx_sh_ff   <= 24'h00_0000;
            bit_cnt_ff <= 5'h00;
            frm_tog_ff <= 1'b0;
        end else begin
            rx_sh_ff <= {rx_sh_ff[22:0], serial_input_line};
            if (first_edge) begin
                bit_cnt_ff <= 5'h01;
                frm_tog_ff <= ~frm_tog_ff;
            end else if (bit_cnt_ff != CNT_OVERLONG) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end

    // Readback shifter; check code or zeros follow the word
    always_ff @(posedge link_sclk or posedge link_clr) begin
        if (link_clr) begin
            tx_sh_ff    <= 24'h00_0000;
            pri_ff      <= 1'b0;
            in_frame_ff <= 1'b0;
        end else begin
            in_frame_ff <= 1'b1;
            pri_ff <= next_out;
            if (first_edge) begin
                tx_sh_ff <= {rb_word_ff[14:0],
                             mode_ff.read_check_en ? rb_check_ff : 8'h00,
                             1'b0};
            end else begin
                tx_sh_ff <= {tx_sh_ff[22:0], 1'b0};
            end
        end
    end

    // Alarm level crosses into the link clock through two flops
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            al_s1_ff <= 1'b0;
            al_s2_ff <= 1'b0;
        end else begin
            al_s1_ff <= alarm_level;
            al_s2_ff <= al_s1_ff;
        end
    end

    // Shared pin: alarm, second data lane, or quiet
    // Limitation: the alarm level only refreshes while the clock runs
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            sec_ff <= 1'b0;
        end else if (mode_ff.alarm_mode) begin
            sec_ff <= al_s2_ff;
        end else if (mode_ff.two_lane && !cs_n) begin
            sec_ff <= next_out;
        end else begin
            sec_ff <= 1'b0;
        end
    end

    assign primary_serial_out      = pri_ff;
    assign secondary_out_alarm_pin = sec_ff;

    ////////////////////////////////////////////////////////////////////
    // Frame end detection in the ref domain
    logic         cs_s1_ff;      // Select synchroniser, first stage
    logic         cs_s2_ff;      // Select synchroniser, second stage
    logic         cs_s3_ff;      // Delayed copy for edge detection
    wire logic    frame_end;     // Select just went high
    logic         tg_s1_ff;      // Frame toggle synchroniser, first stage
    logic         tg_s2_ff;      // Frame toggle synchroniser, second stage
    logic         tg_seen_ff;    // Toggle value of the last evaluated frame
    wire logic    frame_new;     // Frame end that follows at least one edge

    // Link clock has stopped once select is high, so the shifter is still
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff   <= 1'b1;
            tg_s1_ff   <= 1'b0;
            tg_s2_ff   <= 1'b0;
            tg_seen_ff <= 1'b0;
        end else begin
            cs_s1_ff   <= cs_n;
            cs_s2_ff   <= cs_s1_ff;
            cs_s3_ff   <= cs_s2_ff;
            tg_s1_ff   <= frm_tog_ff;
            tg_s2_ff   <= tg_s1_ff;
            tg_seen_ff <= frame_end ? tg_s2_ff : tg_seen_ff;
        end
    end

    // A select pulse with no clock edges leaves the old word in the
    // shifter; the toggle keeps that word from being applied again
    assign frame_end = cs_s2_ff & ~cs_s3_ff;
    assign frame_new = frame_end & (tg_s2_ff ^ tg_seen_ff);

    ////////////////////////////////////////////////////////////////////
    // Command decode
    cfg_one_t     cfg1_ff;       // First configuration register
    logic         lane_ff;       // Output lane count bit
    logic [3:0]   rd_sel_ff;     // Register chosen for readback
    wire logic    has_check;     // Frame carried a check code
    wire logic    len_ok;        // Frame length is legal
    wire logic [15:0] cmd;       // Command word
    wire logic [7:0]  rx_check;  // Received check code
    wire logic [3:0]  cmd_addr;  // Address nibble
    wire cfg_one_t    cmd_cfg1;  // Data viewed as first register
    wire logic    need_check;    // Check code is mandatory
    wire logic    check_ok;      // Received check code matches
    wire logic    accept;        // Frame may change registers
    wire logic    wr_cfg1;       // Accepted write, first register
    wire logic    wr_cfg2;       // Accepted write, second register
    wire logic    wr_rdsel;      // Accepted readback selection
    wire logic    do_soft;       // Soft reset command
    wire logic    do_hard;       // Hard reset command
    wire logic    avg_active;    // Averaging ratio is an active code
    wire logic [11:0] rb_data;   // Data field of readback word

    assign has_check  = (bit_cnt_ff == CNT_WITH_CHECK);
    assign len_ok     = has_check || (bit_cnt_ff == CNT_CMD_ONLY);
    assign cmd        = has_check ? rx_sh_ff[23:8] : rx_sh_ff[15:0];
    assign rx_check   = rx_sh_ff[7:0];
    assign cmd_addr   = cmd[ADDR_MSB:ADDR_LSB];
    assign cmd_cfg1   = cfg_one_t'(cmd[11:0]);
    // Enabled state needs a code to clear; setting needs one too
    assign need_check = cfg1_ff.write_check_en
                      || (cmd_addr == ADDR_CFG_ONE
                          && cmd_cfg1.write_check_en);
    assign check_ok   = has_check && (check_code(cmd) == rx_check);
    // A supplied code must match even when not required
    assign accept     = frame_new && len_ok
                      && (has_check ? check_ok : !need_check);
    assign wr_cfg1    = accept && (cmd_addr == ADDR_CFG_ONE);
    assign wr_cfg2    = accept && (cmd_addr == ADDR_CFG_TWO);
    assign wr_rdsel   = accept && (cmd_addr == ADDR_READ_SELECT);
    assign do_soft    = wr_cfg2
                      && (cmd[RESET_CODE_MSB:0] == RESET_CODE_SOFT);
    assign do_hard    = wr_cfg2
                      && (cmd[RESET_CODE_MSB:0] == RESET_CODE_HARD);
    assign avg_active = (cfg1_ff.averaging_ratio >= RATIO_CODE_MIN)
                      && (cfg1_ff.averaging_ratio <= RATIO_CODE_MAX);
    // Reset field always reads back as zero
    assign rb_data    = (rd_sel_ff == ADDR_CFG_ONE) ? 12'(cfg1_ff) :
                        (rd_sel_ff == ADDR_CFG_TWO) ?
                            {3'h0, lane_ff, 8'h00} : 12'h000;

    ////////////////////////////////////////////////////////////////////
    // Register writes; hard reset overrides the written lane bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg1_ff   <= cfg_one_t'(CFG_ONE_RESET);
            lane_ff   <= LANE_RESET;
            rd_sel_ff <= READ_SEL_RESET;
        end else if (do_hard) begin
            cfg1_ff   <= cfg_one_t'(CFG_ONE_RESET);
            lane_ff   <= LANE_RESET;
            rd_sel_ff <= READ_SEL_RESET;
        end else begin
            if (wr_cfg1) begin
                cfg1_ff <= cmd_cfg1;
            end
            if (wr_cfg2) begin
                lane_ff <= cmd[LANE_COUNT_BIT];
            end
            if (wr_rdsel) begin
                rd_sel_ff <= cmd[3:0];
            end
        end
    end

    // Pulses and the sticky setup fault; a new fault beats the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            soft_reset_pulse    <= 1'b0;
            hard_reset_pulse    <= 1'b0;
            frame_discard_pulse <= 1'b0;
            setup_fault_flag    <= 1'b0;
        end else begin
            soft_reset_pulse    <= do_soft;
            hard_reset_pulse    <= do_hard;
            frame_discard_pulse <= frame_end && !accept;
            if (setup_fault_set) begin
                setup_fault_flag <= 1'b1;
            end else if (do_hard) begin
                setup_fault_flag <= 1'b0;
            end
        end
    end

    // Configuration outputs, one cycle behind the registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resolution_boost   <= 1'b0;
            averaging_on       <= 1'b0;
            averaging_ratio    <= 3'h0;
            reference_external <= 1'b0;
            power_down         <= 1'b0;
            output_lane_count  <= LANE_RESET;
        end else begin
            resolution_boost   <= cfg1_ff.resolution_boost
                                  && avg_active;
            averaging_on       <= avg_active;
            averaging_ratio    <= cfg1_ff.averaging_ratio;
            reference_external <= cfg1_ff.reference_source_select;
            power_down         <= cfg1_ff.power_down_select;
            output_lane_count  <= lane_ff;
        end
    end

    // Words for the link; stable because registers move only after frames
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rb_word_ff  <= 16'h0000;
            rb_check_ff <= 8'h00;
            mode_ff     <= link_mode_t'(3'h0);
        end else begin
            rb_word_ff  <= {rd_sel_ff, rb_data};
            rb_check_ff <= check_code({rd_sel_ff, rb_data});
            mode_ff.read_check_en <= cfg1_ff.read_check_en;
            mode_ff.two_lane      <= !lane_ff;
            mode_ff.alarm_mode    <= lane_ff
                                     && cfg1_ff.alarm_pin_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    property p_set_check;
        @(posedge ref_clk) disable iff (rst)
        $rose(cfg1_ff.write_check_en) |-> $past(check_ok);
    endproperty
    a_set_check: assert property (p_set_check)
        else $error("write check set without valid code");

    property p_discard;
        @(posedge ref_clk) disable iff (rst)
        (frame_end && !accept) |=> $stable(cfg1_ff) && $stable(lane_ff)
                                   && !soft_reset_pulse;
    endproperty
    a_discard: assert property (p_discard)
        else $error("discarded frame changed state");

    property p_clear_check;
        @(posedge ref_clk) disable iff (rst)
        $fell(cfg1_ff.write_check_en) |-> $past(check_ok)
                                          || hard_reset_pulse;
    endproperty
    a_clear_check: assert property (p_clear_check)
        else $error("write check cleared without valid code");

    property p_tail_zero;
        @(posedge link_sclk) disable iff (rst || cs_n)
        (bit_cnt_ff > CNT_CMD_ONLY && !mode_ff.read_check_en)
            |-> !pri_ff;
    endproperty
    a_tail_zero: assert property (p_tail_zero)
        else $error("check bits sent while read check off");

    property p_alarm_gate;
        @(posedge ref_clk) disable iff (rst)
        !lane_ff [*2] |-> !mode_ff.alarm_mode;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate)
        else $error("alarm pin active in two-lane mode");

    property p_res_ignored;
        @(posedge ref_clk) disable iff (rst)
        (cfg1_ff.averaging_ratio == 3'h0) [*2] |-> !resolution_boost;
    endproperty
    a_res_ignored: assert property (p_res_ignored)
        else $error("boost active with averaging off");

    property p_soft_keeps;
        @(posedge ref_clk) disable iff (rst)
        soft_reset_pulse |-> $past(frame_end) && $stable(cfg1_ff);
    endproperty
    a_soft_keeps: assert property (p_soft_keeps)
        else $error("soft reset changed registers");

    property p_hard_clears;
        @(posedge ref_clk) disable iff (rst)
        hard_reset_pulse |-> cfg1_ff == cfg_one_t'(CFG_ONE_RESET)
                             && lane_ff == LANE_RESET
                             && $past(frame_end);
    endproperty
    a_hard_clears: assert property (p_hard_clears)
        else $error("hard reset left registers set");

    property p_other_codes;
        @(posedge ref_clk) disable iff (rst)
        (wr_cfg2 && cmd[7:0] != RESET_CODE_SOFT
                 && cmd[7:0] != RESET_CODE_HARD)
            |=> !soft_reset_pulse && !hard_reset_pulse;
    endproperty
    a_other_codes: assert property (p_other_codes)
        else $error("reset fired on undefined code");

    property p_fault_sticky;
        @(posedge ref_clk) disable iff (rst)
        $fell(setup_fault_flag) |-> hard_reset_pulse;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("setup fault cleared without hard reset");

    c_write: cover property (@(posedge ref_clk) disable iff (rst) wr_cfg1);
    c_soft: cover property (@(posedge ref_clk) disable iff (rst)
        soft_reset_pulse);
    c_hard: cover property (@(posedge ref_clk) disable iff (rst)
        hard_reset_pulse);
    c_discard: cover property (@(posedge ref_clk) disable iff (rst)
        frame_discard_pulse);

endmodule
`default_nettype wire

// File: adc_config_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_config_control_regs_tb
    import adc_cfg_pkg::*;
;
    // Clocks, reset and status inputs
    logic       ref_clk;
    logic       rst;
    logic       alarm_level;
    logic       setup_fault_set;
    // Link wires between host model and device
    wire logic  link_sclk;
    wire logic  cs_n;
    wire logic  sdi_w;
    wire logic  pri_w;
    wire logic  sec_w;
    // Device outputs
    wire logic       boost_o, avg_on_o, ref_o, pd_o, lane_o;
    wire logic [2:0] ratio_o;
    wire logic       soft_o, hard_o, disc_o, fault_o;
    // Outputs gathered as {boost, avg, ratio, ref, pd, lane}
    wire logic [7:0] cfg_now = {boost_o, avg_on_o, ratio_o, ref_o, pd_o,
                                lane_o};
    int         errors;
    int         num_checks;
    int         n_soft, n_hard, n_disc;
    int         s0, h0, d0;
    logic [7:0] pls;

    // Row: word, frame mode, expected outputs, pulse counts {s,h,d}
    typedef struct packed {
        logic [15:0] word;
        logic [1:0]  mode;
        logic [7:0]  cfg;
        logic [7:0]  pls;
    } row_t;
    row_t rows [18];

    adc_config_control_regs DUT (
        .ref_clk(ref_clk), .rst(rst), .link_sclk(link_sclk), .cs_n(cs_n),
        .serial_input_line(sdi_w), .primary_serial_out(pri_w),
        .secondary_out_alarm_pin(sec_w), .alarm_level(alarm_level),
        .setup_fault_set(setup_fault_set), .resolution_boost(boost_o),
        .averaging_on(avg_on_o), .averaging_ratio(ratio_o),
        .reference_external(ref_o), .power_down(pd_o),
        .output_lane_count(lane_o), .soft_reset_pulse(soft_o),
        .hard_reset_pulse(hard_o), .frame_discard_pulse(disc_o),
        .setup_fault_flag(fault_o));

    host_link_model u_host (
        .link_sclk(link_sclk), .cs_n(cs_n), .serial_input_line(sdi_w),
        .primary_serial_out(pri_w), .secondary_out_alarm_pin(sec_w));

    ////////////////////////////////////////////////////////////////////
    // System clock, 40 ns
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // Pulse tallies; a double pulse shows as a count of two
    always @(posedge ref_clk) begin
        if (soft_o === 1'b1) n_soft++;
        if (hard_o === 1'b1) n_hard++;
        if (disc_o === 1'b1) n_disc++;
    end

    ////////////////////////////////////////////////////////////////////
    // Compare tasks and verdict
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp24(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d num_checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Frame plus pulse bookkeeping
    task automatic send(input logic [15:0] w, input logic [1:0] mode);
        s0 = n_soft;
        h0 = n_hard;
        d0 = n_disc;
        u_host.frame(w, mode);
        pls = {2'h0, 2'(n_soft - s0), 2'(n_hard - h0), 2'(n_disc - d0)};
    endtask

    // Hang guard, well past the roughly 19 us of traffic
    initial begin
        #300000;
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        n_soft = 0;
        n_hard = 0;
        n_disc = 0;
        rst = 1'b1;
        alarm_level = 1'b1;
        setup_fault_set = 1'b0;
        rows = '{
            '{16'h1001, 2'd0, 8'h02, 8'h00}, '{16'h1002, 2'd0, 8'h04, 8'h00},
            '{16'h1001, 2'd3, 8'h04, 8'h01}, '{16'h1004, 2'd0, 8'h00, 8'h00},
            '{16'h1044, 2'd0, 8'hC8, 8'h00}, '{16'h1144, 2'd0, 8'hE8, 8'h00},
            '{16'h1184, 2'd0, 8'h30, 8'h00}, '{16'h11C0, 2'd0, 8'h38, 8'h00},
            '{16'h2100, 2'd0, 8'h39, 8'h00}, '{16'h2012, 2'd0, 8'h38, 8'h00},
            '{16'h203C, 2'd0, 8'h38, 8'h10}, '{16'h30FF, 2'd0, 8'h38, 8'h00},
            '{16'h203C, 2'd2, 8'h38, 8'h01}, '{16'h1020, 2'd0, 8'h38, 8'h01},
            '{16'h1021, 2'd1, 8'h02, 8'h00}, '{16'h1000, 2'd0, 8'h02, 8'h01},
            '{16'h1000, 2'd2, 8'h02, 8'h01}, '{16'h1018, 2'd1, 8'h00, 8'h00}};
        repeat (6) @(posedge ref_clk);
        #2 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        // Table of writes, refusals and reset codes
        foreach (rows[i]) begin
            send(rows[i].word, rows[i].mode);
            cmp8(cfg_now, rows[i].cfg);
            cmp8(pls, rows[i].pls);
        end
        // Readback with code; alarm select ignored in two-lane mode
        send(16'h2000, 2'd1);
        cmp24(u_host.rd_pri, {16'h1018, u_host.crc8(16'h1018)});
        cmp24(u_host.rd_sec, {16'h1018, u_host.crc8(16'h1018)});
        // One-lane mode turns the shared pin into the alarm
        send(16'h2100, 2'd1);
        send(16'h2100, 2'd1);
        cmp24(u_host.rd_sec, 24'hFF_FFFF);
        // Sticky setup fault: survives soft reset, hard reset clears
        @(posedge ref_clk) #2 setup_fault_set = 1'b1;
        @(posedge ref_clk) #2 setup_fault_set = 1'b0;
        repeat (3) @(posedge ref_clk);
        cmp8({7'h00, fault_o}, 8'h01);
        send(16'h203C, 2'd1);
        cmp8({7'h00, fault_o}, 8'h01);
        send(16'h20FF, 2'd1);
        cmp8(pls, 8'h04);
        cmp8({fault_o, cfg_now[6:0]}, 8'h00);
        // Defaults after hard reset: read select 1, no read code; one lane
        // with alarm select off keeps the shared pin quiet
        send(16'h2100, 2'd1);
        send(16'h2000, 2'd1);
        cmp24(u_host.rd_pri, 24'h10_0000);
        cmp24(u_host.rd_sec, 24'h00_0000);
        // Mid-run reset clears the outputs
        send(16'h1001, 2'd0);
        @(posedge ref_clk) #2 rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        cmp8(cfg_now, 8'h00);
        #2 rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2 cmp8({fault_o, soft_o, hard_o, disc_o, cfg_now[3:0]}, 8'h00);
        repeat (2) @(posedge ref_clk);
        // Link works again after the mid-run reset
        send(16'h1002, 2'd0);
        cmp8(cfg_now, 8'h04);
        close_out();
    end
endmodule
`default_nettype wire

// File: host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import adc_cfg_pkg::*;
(
    // Serial link toward the device
    output logic            link_sclk,
    output logic            cs_n,
    output logic            serial_input_line,
    // Readback from the device
    input  wire logic       primary_serial_out,
    input  wire logic       secondary_out_alarm_pin
);
    logic [23:0] rd_pri;    // Last frame, primary pin
    logic [23:0] rd_sec;    // Last frame, shared pin

    // Link idle: clock parked low, no frame selected
    initial begin
        link_sclk = 1'b0;
        cs_n = 1'b1;
        serial_input_line = 1'b0;
        rd_pri = 24'h00_0000;
        rd_sec = 24'h00_0000;
    end

    ////////////////////////////////////////////////////////////////////
    // Check code over one word, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CHECK_SEED;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CHECK_POLY : 8'h00);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // One frame: mode 0 word only, 1 good code, 2 bad code, 3 20 edges
    task automatic frame(input logic [15:0] w, input logic [1:0] mode);
        logic [23:0] bits;
        int          n;
        // Code follows the word when asked; bad code flips one bit
        bits = {w, crc8(w) ^ {7'h00, mode == 2'd2}};
        n = (mode == 2'd0) ? 16 : (mode == 2'd3) ? 20 : 24;
        cs_n = 1'b0;
        #20;
        // Data moves 1 ns after the falling edge, sampled on rising
        for (int i = 0; i < n; i++) begin
            serial_input_line = bits[23 - i];
            #5 link_sclk = 1'b1;
            #5 rd_pri[23 - i] = primary_serial_out;
            rd_sec[23 - i] = secondary_out_alarm_pin;
            #1 link_sclk = 1'b0;
            #1;
        end
        #6 cs_n = 1'b1;
        // Released line shows no stale bit
        serial_input_line = ~serial_input_line;
        // Covers frame evaluation and the idle gap between frames
        #400;
    endtask
endmodule
`default_nettype wire
